// ### testbench/high_speed_sysclk_control_tb.sv
// Self-checking bench for the high-speed clock controller.
// Assumes the pin clock model and the bound checker are compiled first.
`default_nettype none
module high_speed_sysclk_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hs_clk_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic osc_gain_range, gain_write, ext_input_select, hs_source_enable, main_source_stop;
  logic main_src_select, main_clock_mode_bit, stop_exec, stop_release, int_tick, hs_clk_in;
  logic cpu_clock_status, gain_band_high, gain_locked, osc_run, cpu_halt;
  logic periph_tick, cpu_tick, stop_mode;
  logic [1:0] pin_mode;
  logic [2:0] cpu_divider_code;
  logic [7:0] hs_half = 8'h19;
  int err_total = 0, n_compared = 0, cyc = 0, n, g, p, e;
  always #10 mclk = ~mclk;
  hs_clk_ctrl uut (.mclk, .rst, .osc_gain_range, .gain_write, .ext_input_select,
    .hs_source_enable, .main_source_stop, .main_src_select, .main_clock_mode_bit,
    .cpu_divider_code, .stop_exec, .stop_release, .int_tick, .hs_clk_in, .cpu_clock_status,
    .gain_band_high, .gain_locked, .pin_mode, .osc_run, .cpu_halt, .periph_tick, .cpu_tick,
    .stop_mode);
  hs_clk_src_model src (.run(osc_run), .half_ns(hs_half), .clk_out(hs_clk_in));
  // ==========
  // Helpers
  always @(negedge mclk)
  begin
    cyc++;
    int_tick <= (cyc % 4 == 0);
    if (cyc > 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task step(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task gap;
    g = 0;
    do
    begin
      step(1);
      g++;
    end
    while (cpu_tick !== 1'b1);
  endtask
  task wait_for(input logic v);
    n = 0;
    while (cpu_clock_status !== v && n < 50) begin step(1); n++; end
  endtask
  task count_halt;
    n = 0;
    while (cpu_halt === 1'b1) begin n++; step(1); end
  endtask
  task count_periph;
    n = 0;
    repeat (100) begin step(1); n += periph_tick; end
  endtask
  function automatic int exp_gap(input logic [2:0] c, input int prev);
    return (c > 3'h4) ? prev : (4 << c);
  endfunction
  // ==========
  // Main sequence
  initial
  begin
    {osc_gain_range, gain_write, ext_input_select, hs_source_enable, stop_exec} = '0;
    {main_src_select, main_clock_mode_bit, stop_release} = '0;
    main_source_stop = 1'b1;
    cpu_divider_code = DIV_RESET;
    void'($urandom(55302));
    step(5);
    rst = 1'b0;
    chk(pin_mode, 0);
    chk(cpu_clock_status, 0);
    gap();
    gap();
    chk(g, 8);
    p = 8;
    for (int i = 0; i < 9; i++)
    begin
      // Code 7 is a prohibited corner; later codes are drawn at random.
      cpu_divider_code = (i < 5) ? 3'(i) : (i == 5) ? 3'h7 : 3'($urandom_range(7, 0));
      e = exp_gap(cpu_divider_code, p);
      gap();
      chk(g, p);
      gap();
      chk(g, e);
      p = e;
    end
    hs_source_enable = 1'b1;
    step(2);
    chk(pin_mode, 1);
    main_source_stop = 1'b0;
    step(2);
    chk(osc_run, 1);
    osc_gain_range = 1'b1;
    pulse(gain_write);
    count_halt();
    chk(n, HALT_XTAL_CYC);
    chk(gain_band_high, 1);
    osc_gain_range = 1'b0;
    pulse(gain_write);
    step(1);
    chk({gain_band_high, cpu_halt}, 2);
    {main_src_select, main_clock_mode_bit} = 2'h3;
    wait_for(1'b1);
    chk(cpu_clock_status, 1);
    count_periph();
    chk(n >= 35 && n <= 45, 1);
    {main_src_select, main_clock_mode_bit} = 2'h0;
    wait_for(1'b0);
    count_periph();
    chk(n, 25);
    main_source_stop = 1'b1;
    step(2);
    chk(osc_run, 0);
    main_source_stop = 1'b0;
    step(2);
    pulse(stop_exec);
    chk({stop_mode, osc_run}, 2);
    pulse(stop_release);
    step(1);
    chk(stop_mode, 0);
    {main_source_stop, hs_source_enable} = 2'h2;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    chk(gain_locked, 0);
    hs_half = 8'h32;
    {ext_input_select, hs_source_enable} = 2'h3;
    step(2);
    chk(pin_mode, 2);
    main_source_stop = 1'b0;
    step(2);
    osc_gain_range = 1'b1;
    pulse(gain_write);
    count_halt();
    chk(n >= 790 && n <= 810, 1);
    wrap_up();
  end
endmodule
`default_nettype wire

// ### testbench/hs_clk_ctrl_assertions.sv
// Checker for the high-speed clock controller, bound to its top ports.
// Assumes int_tick pulses at least once in every 19 mclk cycles.
`default_nettype none
module hs_clk_ctrl_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Controls
  input wire logic osc_gain_range,
  input wire logic gain_write,
  input wire logic ext_input_select,
  input wire logic hs_source_enable,
  input wire logic main_source_stop,
  input wire logic main_src_select,
  input wire logic main_clock_mode_bit,
  input wire logic stop_exec,
  // Outputs
  input wire logic cpu_clock_status,
  input wire logic gain_band_high,
  input wire logic gain_locked,
  input wire logic [1:0] pin_mode,
  input wire logic osc_run,
  input wire logic cpu_halt,
  input wire logic stop_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ==========
  // Properties
  sequence halt_span;
    cpu_halt ##202 cpu_halt ##1 !cpu_halt;
  endsequence
  sequence back_to_int;
    ##[1:20] !cpu_clock_status;
  endsequence
  a_gain_set: assert property (
    gain_write && !gain_locked |=> gain_locked && gain_band_high == $past(osc_gain_range))
    else $error("gain band not latched");
  a_gain_held: assert property (
    gain_locked |=> gain_locked && $stable(gain_band_high))
    else $error("gain band changed twice");
  a_halt_xtal: assert property (
    gain_write && !gain_locked && osc_gain_range && pin_mode == 2'h1 |=> halt_span)
    else $error("crystal halt length wrong");
  a_pin_mode: assert property (
    pin_mode == ($past(hs_source_enable) ? ($past(ext_input_select) ? 2'h2 : 2'h1) : 2'h0))
    else $error("pin mode wrong");
  a_run_start: assert property (
    $fell(main_source_stop) && hs_source_enable && pin_mode != 2'h0 && !stop_exec
      && !stop_mode |=> osc_run)
    else $error("source not started");
  a_run_stop: assert property (
    $rose(main_source_stop) |=> !osc_run)
    else $error("source not stopped");
  a_stop_enter: assert property (
    stop_exec |=> stop_mode && !osc_run)
    else $error("stop mode not entered");
  a_status_rise: assert property (
    $rose(cpu_clock_status) |-> $past(main_src_select && main_clock_mode_bit && osc_run))
    else $error("status rose without request");
  a_status_drop: assert property (
    $fell(main_src_select) |-> back_to_int)
    else $error("status did not return");
endmodule
bind hs_clk_ctrl hs_clk_ctrl_assertions chk_i (.mclk, .rst, .osc_gain_range, .gain_write,
  .ext_input_select, .hs_source_enable, .main_source_stop, .main_src_select,
  .main_clock_mode_bit, .stop_exec, .cpu_clock_status, .gain_band_high, .gain_locked,
  .pin_mode, .osc_run, .cpu_halt, .stop_mode);
`default_nettype wire

// ### testbench/hs_clk_src_model.sv
// Behavioural resonator or external clock feeding the pin input.
// Assumes run is the controller's source-running output.
`default_nettype none
module hs_clk_src_model (
  // Control
  input wire logic run,
  input wire logic [7:0] half_ns,
  // Pin
  output logic clk_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Pin clock
  // A stopped source holds the pin low, so no stray edge can be counted.
  // The start is offset so that no pin edge lands on an mclk sampling edge.
  initial
  begin
    clk_out = 1'b0;
    #3;
    forever
    begin
      #(half_ns);
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verilog/cpu_clk_div.sv
// CPU clock divider: counts main clock ticks and emits one CPU tick per period.
// Assumes src_tick is a one-cycle enable on mclk.
`default_nettype none
module cpu_clk_div
  import hs_clk_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Controller side
  cpu_div_if.div dv
);
  typedef struct packed
  {
    logic [3:0] cnt;
    logic [2:0] code;
    logic tick;
  } div_state_t;
  div_state_t s_r;
  div_state_t s_nxt;
  logic [3:0] limit;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    limit = 4'((5'h1 << s_r.code) - 5'h1);
    if (dv.src_tick)
    begin
      if (s_r.cnt >= limit)
      begin
        s_nxt.cnt = 4'h0;
        s_nxt.tick = 1'b1;
        // A new ratio is latched only when a period ends, so no short pulse. (see R24)
        if (dv.code <= DIV_MAX_CODE)
        begin
          s_nxt.code = dv.code; // see R13
        end
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '{cnt: 4'h0, code: DIV_RESET, tick: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign dv.cpu_tick = s_r.tick;
endmodule
`default_nettype wire

// ### verilog/cpu_div_if.sv
// Carrier between the clock controller and its CPU clock divider.
// Assumes both ends run on mclk.
`default_nettype none
interface cpu_div_if;
  logic src_tick;
  logic [2:0] code;
  logic cpu_tick;
  modport ctrl (output src_tick, output code, input cpu_tick);
  modport div (input src_tick, input code, output cpu_tick);
endinterface
`default_nettype wire

// ### verilog/hs_clk_ctrl.sv
// High-speed system clock control: pin mode, gain band, start/stop, source mux,
// CPU clock halt and CPU divider. Control bits are plain ports from software.
// Assumes hs_clk_in comes from a pin and is sampled here; int_tick is on mclk.
`default_nettype none
module hs_clk_ctrl
  import hs_clk_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Software control bits
  input wire logic osc_gain_range,
  input wire logic gain_write,
  input wire logic ext_input_select,
  input wire logic hs_source_enable,
  input wire logic main_source_stop,
  input wire logic main_src_select,
  input wire logic main_clock_mode_bit,
  input wire logic [2:0] cpu_divider_code,
  input wire logic stop_exec,
  input wire logic stop_release,
  // Clock sources: int_tick as an enable, hs_clk_in as a raw pin level
  input wire logic int_tick,
  input wire logic hs_clk_in,
  // Status and outputs
  output logic cpu_clock_status,
  output logic gain_band_high,
  output logic gain_locked,
  output logic [1:0] pin_mode,
  output logic osc_run,
  output logic cpu_halt,
  output logic periph_tick,
  output logic cpu_tick,
  output logic stop_mode
);
  // ==========
  // State
  typedef struct packed
  {
    logic sync1;
    logic sync2;
    logic hs_prev;
    logic gain;
    logic gain_lock;
    logic [1:0] pmode;
    logic run;
    logic stop;
    sw_state_t sw;
    logic [1:0] settle;
    logic use_hs;
    // Ten bits cover both halt lengths; a longer halt would need a wider field.
    logic [9:0] halt_cnt;
    logic halt;
    logic ptick;
  } ctl_state_t;
  ctl_state_t s_r;
  ctl_state_t s_nxt;
  logic hs_edge;
  logic want_hs;
  cpu_div_if dv ();

  // ==========
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync1 = hs_clk_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.hs_prev = s_r.sync2;
    // Pin edges count only while the source runs, so a pin left in port mode
    // can never advance a counter.
    hs_edge = s_r.sync2 & ~s_r.hs_prev & s_r.run;
    // Pin mode follows the select bits; software keeps them still while running. (see R10)
    if (ext_input_select && hs_source_enable)
    begin
      s_nxt.pmode = PIN_EXT; // see R6
    end
    else if (hs_source_enable)
    begin
      s_nxt.pmode = PIN_XTAL; // see R5
    end
    else
    begin
      s_nxt.pmode = PIN_PORT; // see R20
    end
    // Entry wins over release in one cycle, so a late release cannot cancel a stop.
    if (stop_exec)
    begin
      s_nxt.stop = 1'b1; // see R14
    end
    else if (stop_release)
    begin
      s_nxt.stop = 1'b0;
    end
    // Source runs only when its pins are assigned, unstopped and not in stop mode. (see R8, R17)
    s_nxt.run = hs_source_enable && !main_source_stop && !s_nxt.stop;
    // First write locks the band; later writes are ignored. (see R2)
    s_nxt.ptick = 1'b0;
    if (gain_write && !s_r.gain_lock)
    begin
      s_nxt.gain = osc_gain_range; // see R1
      s_nxt.gain_lock = 1'b1;
      if (osc_gain_range)
      begin
        s_nxt.halt = 1'b1;
        s_nxt.halt_cnt = (s_r.pmode == PIN_EXT) ? 10'(HALT_EXT_EDGES) : 10'(HALT_XTAL_CYC);
      end
    end
    else if (s_r.halt)
    begin
      // External mode counts input clock edges, crystal mode counts mclk. (see R3, R4)
      // An external halt needs a running pin clock; a stopped source keeps it held.
      if (s_r.pmode != PIN_EXT || hs_edge)
      begin
        s_nxt.halt_cnt = s_r.halt_cnt - 10'h1;
        if (s_r.halt_cnt == 10'h1)
        begin
          s_nxt.halt = 1'b0;
        end
      end
    end
    want_hs = main_src_select && main_clock_mode_bit && s_r.run; // see R11
    case (s_r.sw)
      SW_INT:
      begin
        if (want_hs)
        begin
          s_nxt.sw = SW_TO_HS;
          s_nxt.settle = 2'h0;
        end
      end
      SW_TO_HS:
      begin
        // Wait for settled edges of the new source before handing over. (see R23)
        if (hs_edge)
        begin
          s_nxt.settle = s_r.settle + 2'h1;
        end
        // A request withdrawn during the wait cancels the handover, so the status
        // never rises for a source that is no longer wanted.
        if (!want_hs)
        begin
          s_nxt.sw = SW_INT;
        end
        else if (s_r.settle == 2'(SW_SETTLE_CYC))
        begin
          s_nxt.sw = SW_HS;
          s_nxt.use_hs = 1'b1;
        end
      end
      SW_HS:
      begin
        if (!want_hs)
        begin
          s_nxt.sw = SW_TO_INT;
        end
      end
      SW_TO_INT:
      begin
        if (int_tick)
        begin
          s_nxt.sw = SW_INT;
          s_nxt.use_hs = 1'b0; // see R22
        end
      end
      default:
      begin
        s_nxt.sw = SW_INT;
        s_nxt.use_hs = 1'b0;
      end
    endcase
    // Peripheral clock follows the main clock when it is high-speed. (see R12)
    if (s_r.use_hs)
    begin
      s_nxt.ptick = hs_edge;
    end
    else
    begin
      // With the source selected and running but the main clock still internal, peripherals
      // already take the high-speed clock.
      s_nxt.ptick = main_src_select && s_r.run ? hs_edge : int_tick;
    end
  end

  // ==========
  // Registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      // Reset returns to the internal oscillator with ports on both pins. (see R7, R21)
      s_r <= '{sync1: 1'b0, sync2: 1'b0, hs_prev: 1'b0, gain: 1'b0, gain_lock: 1'b0,
               pmode: PIN_PORT, run: 1'b0, stop: 1'b0, sw: SW_INT, settle: 2'h0,
               use_hs: 1'b0, halt_cnt: 10'h0, halt: 1'b0, ptick: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========
  // CPU divider
  assign dv.src_tick = (s_r.use_hs ? hs_edge : int_tick) && !s_r.halt;
  assign dv.code = cpu_divider_code;

  cpu_clk_div u_div (
    .mclk(mclk),
    .rst(rst),
    .dv(dv.div)
  );

  // ==========
  // Outputs
  assign cpu_clock_status = s_r.use_hs; // see R18
  assign gain_band_high = s_r.gain;
  assign gain_locked = s_r.gain_lock;
  assign pin_mode = s_r.pmode;
  assign osc_run = s_r.run;
  assign cpu_halt = s_r.halt;
  assign periph_tick = s_r.ptick;
  assign cpu_tick = dv.cpu_tick;
  assign stop_mode = s_r.stop;
endmodule
`default_nettype wire

// ### verilog/hs_clk_pkg.sv
// Constants and types shared by the high-speed system clock control block.
// Assumes a single 50 MHz mclk domain and an active-high asynchronous reset.
// Function
// R1 - gain bit: 0 low band, 1 high band
// R2 - gain bit changes only once after reset
// R3 - crystal mode gain set halts CPU 4.06-16.12us
// R4 - external mode gain set halts 160 clocks
// R5 - ext 0, source 1: pins serve resonator
// R6 - both 1: pin b clock in, a port
// R7 - after reset both pins are ports
// R8 - stop bit 0 starts source
// R9 - software waits for stabilization before use
// R10 - no pin mode change while source runs
// R11 - select and mode 1: high-speed drives both
// R12 - high-speed main forces high-speed peripheral clock
// R13 - divider codes 0-4 give /1../16, default /2
// R14 - stop instruction halts source
// R15 - software sets stabilization time before stop
// R16 - software halts unsupported peripherals before stop
// R17 - stop bit 1 halts source
// R18 - status reads 0 internal, 1 high-speed
// R19 - software checks status 0 before stopping
// R20 - unused source leaves pins as ports
// R21 - reset selects internal oscillator
// R22 - select 0: internal drives both clocks
// R23 - status changes only after glitch-free switch
// R24 - divider changes at clock boundary
`default_nettype none
package hs_clk_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam real HALT_MIN_US = 4.06;
  localparam real HALT_MAX_US = 16.12;
  // Least time rounds up, longest rounds down; we halt for the least.
  localparam int unsigned HALT_XTAL_CYC = int'($ceil(HALT_MIN_US * CLK_MHZ));
  localparam int unsigned HALT_XTAL_MAX_CYC = int'($floor(HALT_MAX_US * CLK_MHZ));
  localparam int unsigned HALT_EXT_EDGES = 160;
  localparam int unsigned SW_SETTLE_CYC = 2;
  localparam logic [2:0] DIV_RESET = 3'h1;
  localparam logic [2:0] DIV_MAX_CODE = 3'h4;
  typedef enum logic [1:0] {PIN_PORT, PIN_XTAL, PIN_EXT} pin_mode_t;
  typedef enum {SW_INT, SW_TO_HS, SW_HS, SW_TO_INT} sw_state_t;
endpackage
`default_nettype wire
